// ### standard_timer.v
// Standard timer: PWM with duty swap, single pulse output and input capture
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "std_timer_regs.vh"

// Operation
// - Duty swap set: period from compare A, duty is coarse period times 256, zero means 65536.
// - Internal PWM keeps running while the pin is forced inactive or active.
// - PWM ignores counter clear select; the swap-chosen period register clears the counter.
// - Single pulse: run bit rising starts counter and drives the pulse leading edge.
// - Single pulse: external clock pin active edge sets the run bit.
// - Single pulse: clearing run ends pulse; compare A match clears run bit.
// - Single pulse: compare A match also raises the interrupt request.
// - Single pulse: counter resets only on run rising; period, clear and swap unused.
// - Mode 01 selects capture, counter sampled by capture pin edges.
// - Capture: counter starts on run rising and free-runs until run falls.
// - Capture: active edge copies counter into compare A and raises interrupt.
// - Capture: pin function picks edges; 11 disables capture, counter still runs.
// - Capture: compare P match clears counter and raises interrupt.
// - Capture: coarse period zero lets counter run to full maximum.
// - Capture pulses narrower than one timer clock may be ignored.
// - Compare A flag rises half a timer clock after the capture latch; here one system clock later.
// - Capture edge to latch takes under one and a half timer clocks.
// - Capture has no output; initial level, polarity, clear and swap ignored.
// - Coarse period compares counter bits 15 to 8 once bits 7 to 0 are all ones, in 256-clock steps.
// - Polarity inverts PWM output; initial level applied when run rises.
// - Mode 00 compare, 10 PWM or single pulse, 11 timer/counter, 01 capture.
module standard_timer #(
    parameter CW = 16
) (
    input  wire        clk,
    input  wire        rst,
    input  wire [3:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    input  wire [3:0]  byteenable,
    output reg  [31:0] readdata,
    output wire        waitrequest,
    input  wire        count_tick,
    input  wire        external_clock_pin,
    input  wire        capture_input_pin,
    output reg         timer_out,
    output wire        timer_irq
);

    reg  [8:0]     ctrl;
    reg  [15:0]    compare_a_value;
    reg  [7:0]     coarse_period_value;
    reg  [CW-1:0]  count;
    reg            compare_a_flag;
    reg            compare_p_flag;
    reg            run_d;
    reg            ext_d;
    reg            cap_d;
    reg            pwm_level;
    reg            read_ack;
    reg            next_run;
    reg            cap_edge;
    reg            a_pend;
    reg  [31:0]    next_readdata;

    wire run_bit            = ctrl[`F_RUN];
    wire duty_swap_select   = ctrl[`F_DPX];
    wire output_polarity    = ctrl[`F_POL];
    wire output_initial_level = ctrl[`F_OC];
    wire [1:0] pin_function = {ctrl[`F_IO_HI], ctrl[`F_IO_LO]};
    wire [1:0] op_mode      = {ctrl[`F_M_HI], ctrl[`F_M_LO]};

    // Mode decode; compare and timer modes only count with a 16-bit wrap
    wire mode_cmp   = (op_mode == `MODE_CMP);
    wire mode_tc    = (op_mode == `MODE_TC);
    wire mode_cap   = (op_mode == `MODE_CAP);
    // Mode 10 splits on the pin function: code 11 is the one-shot
    wire mode_pwm   = (op_mode == `MODE_PWM) && (pin_function != `PF_PULSE);
    wire mode_pulse = (op_mode == `MODE_PWM) && (pin_function == `PF_PULSE);

    // Forced pin levels of PWM mode, polarity applied on top
    wire forced_low  = output_polarity;
    wire forced_high = ~output_polarity;

    ////////////////////////////////////////////////////////////////////////
    // Comparators
    wire run_rise  = run_bit & ~run_d;
    // Match on the last count of the period, so a value of n gives n times 256 ticks
    wire p_match   = (coarse_period_value == 8'h00) ? (count == 16'hffff)
                     : (count[15:8] == (coarse_period_value - 8'h01)) && (count[7:0] == 8'hff);
    wire a_match   = (count == compare_a_value);
    // Duty of coarse value, zero standing for 65536 (17 bits)
    wire [16:0] duty_len = (coarse_period_value == 8'h00) ? 17'h10000
                           : {1'b0, coarse_period_value, 8'h00};
    wire [16:0] per_len  = {1'b0, compare_a_value} + 17'h00001;
    wire pwm_clear = duty_swap_select ? a_match : p_match;
    wire pwm_active = duty_swap_select
                      ? ((duty_len >= per_len) || ({1'b0, count} < duty_len))
                      : (count < compare_a_value);

    ////////////////////////////////////////////////////////////////////////
    // Capture edge detection on timer ticks; a level must persist across ticks
    always @* begin
        case (pin_function)
            2'h0:    cap_edge = capture_input_pin & ~cap_d;
            2'h1:    cap_edge = ~capture_input_pin & cap_d;
            2'h2:    cap_edge = capture_input_pin ^ cap_d;
            default: cap_edge = 1'b0;
        endcase
    end

    // Single pulse: external edge sets run, compare A clears it
    wire ext_edge = external_clock_pin & ~ext_d;
    wire bus_wr_ctrl = write && (address == `CTRL_OFF) && byteenable[0];
    always @* begin
        next_run = run_bit;
        if (bus_wr_ctrl)
            next_run = writedata[`F_RUN];
        if (mode_pulse && ext_edge)
            next_run = 1'b1;
        if (mode_pulse && run_bit && count_tick && a_match)
            next_run = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus strobes per register; byte lanes gate each field
    wire bus_wr_compare_a_value_lo = write && (address == `COMPARE_A_VALUE_OFF) && byteenable[0];
    wire bus_wr_compare_a_value_hi = write && (address == `COMPARE_A_VALUE_OFF) && byteenable[1];
    wire bus_wr_coarse_period_value    = write && (address == `COARSE_PERIOD_VALUE_OFF) && byteenable[0];
    wire bus_wr_flags   = write && (address == `CTRL_OFF) && byteenable[1];

    // Timer step: a tick while running; the restart edge takes priority
    wire tick_run  = run_bit && count_tick && !run_rise;
    wire cap_latch = tick_run && mode_cap && cap_edge;

    ////////////////////////////////////////////////////////////////////////
    // Edge history registers
    // Run history gives the restart edge of every mode
    always @(posedge clk) begin
        if (rst) begin
            run_d <= 1'b0;
        end else begin
            run_d <= run_bit;
        end
    end

    // Trigger pin history, sampled every clock so short triggers count
    always @(posedge clk) begin
        if (rst) begin
            ext_d <= 1'b0;
        end else begin
            ext_d <= external_clock_pin;
        end
    end

    // Capture pin history moves on ticks only; narrower pulses are lost
    always @(posedge clk) begin
        if (rst) begin
            cap_d <= 1'b0;
        end else if (tick_run) begin
            cap_d <= capture_input_pin;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and value registers
    // Control word; the run bit follows its own next value
    always @(posedge clk) begin
        if (rst) begin
            ctrl <= `CTRL_RST;
        end else begin
            if (bus_wr_ctrl) begin
                ctrl <= writedata[8:0];
            end
            ctrl[`F_RUN] <= next_run;
        end
    end

    // Compare A: bus bytes, and a capture overwrites the whole word
    always @(posedge clk) begin
        if (rst) begin
            compare_a_value <= `COMPARE_A_VALUE_RST;
        end else if (cap_latch) begin
            compare_a_value <= count;
        end else begin
            if (bus_wr_compare_a_value_lo) begin
                compare_a_value[7:0] <= writedata[7:0];
            end
            if (bus_wr_compare_a_value_hi) begin
                compare_a_value[15:8] <= writedata[15:8];
            end
        end
    end

    // Coarse period, compared against the counter's top byte while the low byte is ff
    always @(posedge clk) begin
        if (rst) begin
            coarse_period_value <= `COARSE_PERIOD_VALUE_RST;
        end else if (bus_wr_coarse_period_value) begin
            coarse_period_value <= writedata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags
    // Capture flag waits one system clock, standing in for the half tick
    always @(posedge clk) begin
        if (rst) begin
            a_pend <= 1'b0;
        end else begin
            a_pend <= cap_latch;
        end
    end

    // Compare A flag: write one clears, a set in the same cycle wins
    always @(posedge clk) begin
        if (rst) begin
            compare_a_flag <= 1'b0;
        end else if (a_pend) begin
            compare_a_flag <= 1'b1;
        end else if (tick_run && (mode_pwm || mode_pulse) && a_match) begin
            compare_a_flag <= 1'b1;
        end else if (bus_wr_flags && writedata[`F_AFLAG]) begin
            compare_a_flag <= 1'b0;
        end
    end

    // Compare P flag: period match in capture and PWM modes
    always @(posedge clk) begin
        if (rst) begin
            compare_p_flag <= 1'b0;
        end else if (tick_run && (mode_cap || mode_pwm) && p_match) begin
            compare_p_flag <= 1'b1;
        end else if (bus_wr_flags && writedata[`F_PFLAG]) begin
            compare_p_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter: restart on run rising, then one step per tick
    always @(posedge clk) begin
        if (rst) begin
            count <= {CW{1'b0}};
        end else if (run_rise) begin
            count <= {CW{1'b0}};
        end else if (tick_run) begin
            if (mode_cap) begin
                // Free-runs whatever the capture pin does
                count <= p_match ? {CW{1'b0}} : count + 1'b1;
            end else if (mode_pwm) begin
                // Clear select ignored; swap picks the clearing register
                count <= pwm_clear ? {CW{1'b0}} : count + 1'b1;
            end else if (mode_pulse) begin
                // Only the run edge clears it; period, clear and swap unused
                count <= count + 1'b1;
            end else begin
                // Compare and timer modes wrap at the full width
                count <= count + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // PWM level is registered so the pin sees a settled compare result
    always @(posedge clk) begin
        if (rst) begin
            pwm_level <= 1'b0;
        end else begin
            pwm_level <= pwm_active;
        end
    end

    // Output pin; capture mode holds it low, compare and timer modes keep the initial level
    always @(posedge clk) begin
        if (rst) begin
            timer_out <= 1'b0;
        end else begin
            if (run_rise && !mode_cap)
                timer_out <= output_initial_level;
            else if (mode_pwm) begin
                case (pin_function)
                    `PF_LO:  timer_out <= forced_low;
                    `PF_HI:  timer_out <= forced_high;
                    default: timer_out <= pwm_level ^ output_polarity;
                endcase
            end else if (mode_pulse)
                timer_out <= run_bit ^ output_polarity;
            else if (mode_cap)
                timer_out <= 1'b0;
        end
    end

    // Interrupt request is the OR of the sticky compare flags
    assign timer_irq = compare_a_flag | compare_p_flag;

    ////////////////////////////////////////////////////////////////////////
    // Avalon slave: writes take one cycle, reads answer on the second
    assign waitrequest = read & ~read_ack;

    // Read multiplexer; the control word carries the capture pin at bit 11
    always @* begin
        next_readdata = 32'h0000_0000;
        case (address)
            `CTRL_OFF:  next_readdata = {20'h00000, capture_input_pin, compare_p_flag, compare_a_flag, ctrl};
            `COMPARE_A_VALUE_OFF:  next_readdata = {16'h0000, compare_a_value};
            `COARSE_PERIOD_VALUE_OFF:  next_readdata = {24'h000000, coarse_period_value};
            `COUNT_OFF: next_readdata = {16'h0000, count};
            default:    next_readdata = 32'h0000_0000;
        endcase
    end

    // Read data is taken in the stalled cycle and holds until the next read
    always @(posedge clk) begin
        if (rst) begin
            read_ack <= 1'b0;
            readdata <= 32'h0000_0000;
        end else begin
            read_ack <= read & ~read_ack;
            if (read && !read_ack) begin
                readdata <= next_readdata;
            end
        end
    end

endmodule

// ### std_timer_regs.vh
// Register offsets, field positions, mode and pin codes and reset values of the standard timer
`ifndef STD_TIMER_REGS_VH
`define STD_TIMER_REGS_VH

// Word byte addresses on the Avalon-MM slave
`define CTRL_OFF        4'h0
`define COMPARE_A_VALUE_OFF        4'h4
`define COARSE_PERIOD_VALUE_OFF        4'h8
`define COUNT_OFF       4'hc

// Control register fields
`define F_RUN           0
`define F_DPX           1
`define F_CCLR          2
`define F_POL           3
`define F_OC            4
`define F_IO_LO         5
`define F_IO_HI         6
`define F_M_LO          7
`define F_M_HI          8
`define F_AFLAG         9
`define F_PFLAG         10
`define F_PIN           11
`define CTRL_WMASK      32'h0000_01ff

// Operating modes
`define MODE_CMP        2'h0
`define MODE_CAP        2'h1
`define MODE_PWM        2'h2
`define MODE_TC         2'h3

// Pin function codes
`define PF_LO           2'h0
`define PF_HI           2'h1
`define PF_PWM          2'h2
`define PF_PULSE        2'h3

// Reset values
`define CTRL_RST        9'h000
`define COMPARE_A_VALUE_RST        16'h0000
`define COARSE_PERIOD_VALUE_RST        8'h00

`endif

// ### standard_timer_chk.sv
// Port checker for the standard timer
`timescale 1ns/100ps
module standard_timer_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        read,
    input wire logic        write,
    input wire logic        count_tick,
    input wire logic        external_clock_pin,
    input wire logic        waitrequest,
    input wire logic [31:0] readdata,
    input wire logic        timer_out,
    input wire logic        timer_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    // Bus answers
    chk_read_stall: assert property ($rose(read) |-> waitrequest) else $error("read not stalled");
    chk_read_answer: assert property (read && waitrequest |=> !waitrequest) else $error("read never answered");
    chk_write_free: assert property (write |-> !waitrequest) else $error("write stalled");
    chk_read_hold: assert property (!read && !$past(read) |-> $stable(readdata)) else $error("read data moved");
    // Pins quiet after reset; nothing moves without a timer clock, trigger or write
    chk_reset_quiet: assert property ($fell(rst) |-> !timer_out && !timer_irq) else $error("pins not idle");
    chk_out_quiet: assert property ((!count_tick && !write && !external_clock_pin) [*5] |=> $stable(timer_out))
        else $error("output moved without cause");
    chk_irq_quiet: assert property ((!count_tick && !write) [*5] |=> !$rose(timer_irq))
        else $error("request raised without timer clock");
    chk_irq_clear: assert property ($fell(timer_irq) |-> $past(write)) else $error("request dropped alone");
endmodule
bind standard_timer standard_timer_chk chk (.clk(clk), .rst(rst), .read(read), .write(write),
    .count_tick(count_tick), .external_clock_pin(external_clock_pin), .waitrequest(waitrequest),
    .readdata(readdata), .timer_out(timer_out), .timer_irq(timer_irq));

// ### timer_pins.sv
// Pin-side partner: timer clock enable, trigger and capture pulses
`timescale 1ns/100ps
module timer_pins (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic trig_go,
    input  wire logic cap_go,
    output wire logic count_tick,
    output wire logic external_clock_pin,
    output wire logic capture_input_pin
);
    logic [2:0] div;
    logic [4:0] hold_trig;
    logic [4:0] hold_cap;
    ////////////////////////////////////////////////////////////////
    // Slow tick leaves quiet gaps; the timer clock never stops
    always @(posedge clk) begin
        div       <= rst ? 3'h0 : div + 3'h1;
        hold_trig <= rst ? 5'h0 : trig_go ? 5'h18 : hold_trig - 5'(hold_trig != 5'h0);
        hold_cap  <= rst ? 5'h0 : cap_go ? 5'h18 : hold_cap - 5'(hold_cap != 5'h0);
    end
    // Pulses span three timer clocks, wide enough to be seen
    assign count_tick         = (div == 3'h7);
    assign external_clock_pin = (hold_trig != 5'h0);
    assign capture_input_pin  = (hold_cap != 5'h0);
endmodule

// ### tb_standard_timer_pulse_capture_modes.sv
// Self-checking bench for the timer pulse and capture modes
`timescale 1ns/100ps
`include "std_timer_regs.vh"
module tb_standard_timer_pulse_capture_modes;
    logic        clk, rst, read, write, trig_go, cap_go, waitrequest, timer_out, timer_irq;
    logic        count_tick, external_clock_pin, capture_input_pin;
    logic [3:0]  address, byteenable;
    logic [31:0] writedata, readdata, q, c;
    int          fails = 0, checked = 0, waited;
    logic [3:0]  row_addr [5] = '{`COMPARE_A_VALUE_OFF, `COARSE_PERIOD_VALUE_OFF, `CTRL_OFF, 4'h2, `COUNT_OFF};
    logic [31:0] row_data [5] = '{32'h1234, 32'h1ff, 32'haa, 32'h5555, 32'hffff};
    logic [31:0] row_exp  [5] = '{32'h1234, 32'hff, 32'haa, 32'h0, 32'h0};
    standard_timer uut (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .count_tick(count_tick), .external_clock_pin(external_clock_pin),
        .capture_input_pin(capture_input_pin), .timer_out(timer_out), .timer_irq(timer_irq));
    timer_pins pins (.clk(clk), .rst(rst), .trig_go(trig_go), .cap_go(cap_go), .count_tick(count_tick),
        .external_clock_pin(external_clock_pin), .capture_input_pin(capture_input_pin));
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected value at %0t: %s", $time, m);
        end
    endtask
    // One bus transfer, held until waitrequest is seen low
    task automatic xfer(input logic rd, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        address <= a; writedata <= d; read <= rd; write <= ~rd;
        do begin @(posedge clk); n++; end while (waitrequest !== 1'b0 && n < 100);
        q = readdata;
        read <= 1'b0; write <= 1'b0;
        if (n >= 100) begin fails++; end_of_test(); end
    endtask
    // Bounded wait for the output (0) or the request (1) to reach a level
    task automatic wait_sig(input logic irq, input logic v);
        waited = 0;
        do begin @(posedge clk); waited++; end while ((irq ? timer_irq : timer_out) !== v && waited < 400);
        if (waited >= 400) begin fails++; end_of_test(); end
    endtask
    task automatic pulse_go(input logic trig);
        if (trig) trig_go <= 1'b1; else cap_go <= 1'b1;
        @(posedge clk);
        trig_go <= 1'b0; cap_go <= 1'b0;
    endtask
    initial begin
        rst = 1'b1; read = 1'b0; write = 1'b0; address = 4'h0; writedata = 32'h0;
        byteenable = 4'hf; trig_go = 1'b0; cap_go = 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        // Register rows, unmapped and read-only places among them
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, row_addr[i], row_data[i]);
            xfer(1'b1, row_addr[i], 32'h0);
            chk(q, row_exp[i], "register readback");
        end
        // Software pulse, width from compare A, then a pin-triggered one
        xfer(1'b0, `COARSE_PERIOD_VALUE_OFF, 32'h0);
        xfer(1'b0, `COMPARE_A_VALUE_OFF, 32'h10);
        xfer(1'b0, `CTRL_OFF, 32'h161);
        wait_sig(1'b0, 1'b1);
        wait_sig(1'b0, 1'b0);
        chk(waited > 100 && waited < 160, 32'h1, "pulse width");
        xfer(1'b1, `CTRL_OFF, 32'h0);
        chk(q & 32'h201, 32'h200, "run and flag after pulse");
        xfer(1'b0, `CTRL_OFF, 32'h360);
        pulse_go(1'b1);
        wait_sig(1'b0, 1'b1);
        wait_sig(1'b0, 1'b0);
        // Capture on rising edges, then with capture disabled
        xfer(1'b0, `CTRL_OFF, 32'h600);
        xfer(1'b0, `CTRL_OFF, 32'h681);
        repeat (40) @(posedge clk);
        pulse_go(1'b0);
        wait_sig(1'b1, 1'b1);
        xfer(1'b1, `COMPARE_A_VALUE_OFF, 32'h0);
        c = q;
        xfer(1'b1, `COUNT_OFF, 32'h0);
        chk(q - c < 32'h3 && c != 32'h10, 32'h1, "captured count");
        xfer(1'b0, `CTRL_OFF, 32'h6e1);
        pulse_go(1'b0);
        repeat (80) @(posedge clk);
        chk(timer_irq, 1'b0, "capture while disabled");
        xfer(1'b1, `COUNT_OFF, 32'h0);
        chk(q > c + 32'h4, 32'h1, "counter stalled");
        // Duty swap with zero coarse period holds the output active
        xfer(1'b0, `CTRL_OFF, 32'h600);
        xfer(1'b0, `COMPARE_A_VALUE_OFF, 32'h8);
        xfer(1'b0, `CTRL_OFF, 32'h147);
        repeat (16) @(posedge clk);
        waited = 0;
        repeat (100) begin @(posedge clk); waited += (timer_out !== 1'b1); end
        chk(waited, 32'h0, "full duty");
        xfer(1'b1, `COUNT_OFF, 32'h0);
        chk(q < 32'h9, 32'h1, "period from compare A");
        xfer(1'b0, `CTRL_OFF, 32'h107);
        repeat (16) @(posedge clk);
        chk(timer_out, 1'b0, "forced inactive");
        xfer(1'b1, `COUNT_OFF, 32'h0);
        chk(q < 32'h9, 32'h1, "counting while forced");
        xfer(1'b0, `CTRL_OFF, 32'h127);
        repeat (16) @(posedge clk);
        chk(timer_out, 1'b1, "forced active");
        xfer(1'b1, `COUNT_OFF, 32'h0);
        chk(q < 32'h9, 32'h1, "counting while forced high");
        end_of_test();
    end
endmodule
